// *** include/conv_mux_map.svh ***
// register map, field positions and reset values of the conversion source mux
// assumes inclusion by bare name from the include folder
`ifndef CONV_MUX_MAP_SVH
`define CONV_MUX_MAP_SVH

// ----------------------------------------------------------------------------
// byte addresses on the avalon slave
// ----------------------------------------------------------------------------
`define ADDR_SOURCE_SELECT 12'h344
`define ADDR_FRAME_TIMER 12'h348
`define ADDR_LINE_INPUTS 12'h354
`define ADDR_IRQ_STATUS 12'h370
`define ADDR_IRQ_MASK 12'h374

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define POS_CLK_ONE_SEL 0
`define POS_CLK_TWO_SEL 2
`define POS_FTRIG_SEL 4
`define POS_FT_ENABLE 31
`define POS_FT_CLK_SEL 30
`define POS_FT_FLAG 29
`define POS_FT_RELOAD_MSB 27
`define IRQ_BIT_EXPIRE 0
`define IRQ_BIT_TRIGGER 1

// ----------------------------------------------------------------------------
// source codes and front line indices
// ----------------------------------------------------------------------------
`define SEL_REAR 2'h2
`define SEL_FRONT 2'h3
`define FRONT_IDX_CLK_ONE 0
`define FRONT_IDX_CLK_TWO 2
`define FRONT_IDX_FTRIG 4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_SOURCE_SELECT 6'h00
`define RST_FT_RELOAD 28'hfffffff
`define RST_IRQ 2'h0

`endif

// *** include/conv_mux_pkg.sv ***
// types shared by the conversion source mux and its synchroniser
// assumes nothing of its surroundings
package conv_mux_pkg;

    // ------------------------------------------------------------------------
    // frame timer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        FT_IDLE = 2'b00,
        FT_RUN = 2'b01,
        FT_DONE = 2'b10
    } ft_state_t;

    // ------------------------------------------------------------------------
    // state records
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] level;
        logic [2:0] prev;
    } sync_state_t;

    typedef struct packed {
        logic [5:0] src_sel;
        logic ft_enable;
        logic ft_clk_sel;
        logic ft_flag;
        logic [27:0] ft_reload;
        logic [27:0] ft_count;
        ft_state_t ft_state;
        logic expire_pulse;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic ack;
        logic [31:0] readdata;
    } mux_state_t;

endpackage : conv_mux_pkg

// *** rtl/edge_sync.sv ***
// two-stage synchroniser with rising edge detect for the three routed signals
// assumes one clock, synchronous active-high reset, clock enable freezes it
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
    input wire logic ref_clk, // logic clock
    input wire logic rst, // synchronous reset
    input wire logic clk_en, // freezes state when low
    input wire logic [2:0] raw_in, // selected raw sources
    output logic [2:0] level_out, // synchronised levels
    output logic [2:0] rise_out // one-cycle rising edge
);
    import conv_mux_pkg::*;

    sync_state_t s;
    sync_state_t next_s;

    // ------------------------------------------------------------------------
    // shift chain: meta feeds only level
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.meta = raw_in;
        next_s.level = s.meta; // RULE_13
        next_s.prev = s.level;
    end

    // registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else if (clk_en)
        begin
            s <= next_s;
        end
    end

    // edge detect looks at synchronised stages only
    assign level_out = s.level;
    assign rise_out = s.level & ~s.prev & {3{clk_en}}; // RULE_13

endmodule : edge_sync

`default_nettype wire

// *** rtl/conversion_signal_mux_frame_timer.sv ***
// conversion signal source mux, frame timer and line level readback
// assumes an avalon-mm master, all inputs synchronous to ref_clk
//
// What this block does
// RULE_01: clock one source: internal, rear, front line 1
// RULE_02: clock two source: internal, rear, front line 3
// RULE_03: frame trigger source: internal, rear, front line 5
// RULE_04: all source fields reset to internal
// RULE_05: enabled trigger event restarts the timer
// RULE_06: timer counts clock one or clock two
// RULE_07: expiry after reload value plus one cycles
// RULE_08: expiry sets read-only event flag
// RULE_09: next trigger event clears the flag
// RULE_10: twenty line levels always readable
// RULE_11: input bits show real pin level
// RULE_12: software picks external sources, drivers off (this block has no line driver control; front_digital_line is input only)
// RULE_13: sources synchronised, rising edges detected
`timescale 1ns/1ps
`default_nettype none
`include "conv_mux_map.svh"

module conversion_signal_mux_frame_timer (
    input wire logic ref_clk, // logic clock, 40 mhz
    input wire logic rst, // synchronous reset
    input wire logic clk_en, // freezes state when low
    input wire logic [11:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic int_conv_clock_one, // internal clock one generator
    input wire logic int_conv_clock_two, // internal clock two generator
    input wire logic int_frame_trigger, // internal frame trigger generator
    input wire logic rear_conv_clock_one_in, // rear clock one input
    input wire logic rear_conv_clock_two_in, // rear clock two input
    input wire logic rear_frame_trigger_in, // rear frame trigger input
    input wire logic [19:0] front_digital_line, // front line levels
    output logic seq_conv_clock_one, // routed clock one
    output logic seq_conv_clock_two, // routed clock two
    output logic seq_frame_trigger, // routed frame trigger
    output logic frame_timer_expired, // expiry pulse
    output conv_mux_pkg::ft_state_t timer_state, // frame timer state
    output logic irq // level interrupt
);
    import conv_mux_pkg::*;

    mux_state_t s;
    mux_state_t next_s;
    logic [2:0] raw_sel;
    logic [2:0] sync_level;
    logic [2:0] sync_rise;
    logic trig_rise;
    logic clk_rise;
    logic req;
    logic wr_take;
    logic [31:0] read_mux;
    logic [1:0] irq_set;
    logic [31:0] merged;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // two-bit source code to routed level
    function automatic logic src_mux(input logic [1:0] sel, input logic internal_src,
                                     input logic rear_src, input logic front_src);
        logic r;
        r = internal_src;
        if (sel == `SEL_REAR)
        begin
            r = rear_src;
        end
        else if (sel == `SEL_FRONT)
        begin
            r = front_src;
        end
        return r;
    endfunction : src_mux

    // byte lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // ------------------------------------------------------------------------
    // source routing
    // ------------------------------------------------------------------------

    // raw mux ahead of the synchroniser
    assign raw_sel[0] = src_mux(s.src_sel[`POS_CLK_ONE_SEL +: 2], int_conv_clock_one,
                                rear_conv_clock_one_in, front_digital_line[`FRONT_IDX_CLK_ONE]); // RULE_01
    assign raw_sel[1] = src_mux(s.src_sel[`POS_CLK_TWO_SEL +: 2], int_conv_clock_two,
                                rear_conv_clock_two_in, front_digital_line[`FRONT_IDX_CLK_TWO]); // RULE_02
    assign raw_sel[2] = src_mux(s.src_sel[`POS_FTRIG_SEL +: 2], int_frame_trigger,
                                rear_frame_trigger_in, front_digital_line[`FRONT_IDX_FTRIG]); // RULE_03

    // synchronise into the logic clock domain
    edge_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .raw_in(raw_sel),
        .level_out(sync_level),
        .rise_out(sync_rise)
    );

    // routed signals toward the sequencers
    assign seq_conv_clock_one = sync_level[0];
    assign seq_conv_clock_two = sync_level[1];
    assign seq_frame_trigger = sync_level[2];

    // events feeding the frame timer
    assign trig_rise = sync_rise[2]; // RULE_13
    assign clk_rise = s.ft_clk_sel ? sync_rise[1] : sync_rise[0]; // RULE_06

    // ------------------------------------------------------------------------
    // avalon slave decode
    // ------------------------------------------------------------------------

    // one wait state on every access
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~(s.ack & clk_en); // stays high while frozen
    assign wr_take = avs_write & s.ack;

    // read word selection, unmapped reads zero
    always_comb
    begin
        read_mux = 32'h0000_0000;
        unique case (avs_address)
            `ADDR_SOURCE_SELECT: read_mux = {26'h0, s.src_sel};
            `ADDR_FRAME_TIMER: read_mux = {s.ft_enable, s.ft_clk_sel, s.ft_flag, 1'b0, s.ft_reload};
            `ADDR_LINE_INPUTS: read_mux = {12'h000, front_digital_line}; // RULE_10 RULE_11
            `ADDR_IRQ_STATUS: read_mux = {30'h0, s.irq_status};
            `ADDR_IRQ_MASK: read_mux = {30'h0, s.irq_mask};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.expire_pulse = 1'b0;
        irq_set = 2'h0;
        // old word with the enabled write lanes merged in
        merged = lane_merge(read_mux, avs_writedata, avs_byteenable);

        // bus handshake and read capture
        next_s.ack = req & ~s.ack;
        if (req && !s.ack)
        begin
            next_s.readdata = read_mux;
        end

        // software writes
        if (wr_take)
        begin
            unique case (avs_address)
                `ADDR_SOURCE_SELECT:
                begin
                    next_s.src_sel = merged[5:0];
                end
                `ADDR_FRAME_TIMER:
                begin
                    next_s.ft_enable = merged[`POS_FT_ENABLE];
                    next_s.ft_clk_sel = merged[`POS_FT_CLK_SEL];
                    next_s.ft_reload = merged[`POS_FT_RELOAD_MSB:0];
                end
                `ADDR_IRQ_STATUS:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.irq_status = s.irq_status & ~avs_writedata[1:0];
                    end
                end
                `ADDR_IRQ_MASK:
                begin
                    if (avs_byteenable[0])
                    begin
                        next_s.irq_mask = avs_writedata[1:0];
                    end
                end
                default:
                begin
                    next_s.ack = 1'b0;
                end
            endcase
        end

        // frame timer: trigger first, then counting
        if (!s.ft_enable)
        begin
            next_s.ft_state = FT_IDLE;
        end
        else if (trig_rise)
        begin
            next_s.ft_count = 28'h0000000; // RULE_05
            next_s.ft_state = FT_RUN; // RULE_05
        end
        else if (s.ft_state == FT_RUN && clk_rise)
        begin
            if (s.ft_count == s.ft_reload)
            begin
                next_s.ft_state = FT_DONE; // RULE_07
                next_s.ft_flag = 1'b1; // RULE_08
                next_s.expire_pulse = 1'b1;
                irq_set[`IRQ_BIT_EXPIRE] = 1'b1;
            end
            else
            begin
                next_s.ft_count = s.ft_count + 28'h0000001; // RULE_07
            end
        end

        // next trigger event clears the expiry flag
        if (trig_rise)
        begin
            next_s.ft_flag = 1'b0; // RULE_09
            irq_set[`IRQ_BIT_TRIGGER] = 1'b1;
        end

        // sticky status, set wins over clear
        next_s.irq_status = next_s.irq_status | irq_set;

        // read-back path must not miss the handshake release
        if (!req)
        begin
            next_s.ack = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s.src_sel <= `RST_SOURCE_SELECT; // RULE_04
            s.ft_enable <= 1'b0; // RULE_05
            s.ft_clk_sel <= 1'b0;
            s.ft_flag <= 1'b0;
            s.ft_reload <= `RST_FT_RELOAD;
            s.ft_count <= 28'h0000000;
            s.ft_state <= FT_IDLE;
            s.expire_pulse <= 1'b0;
            s.irq_status <= `RST_IRQ;
            s.irq_mask <= `RST_IRQ;
            s.ack <= 1'b0;
            s.readdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            s <= next_s;
        end
    end

    // outputs
    assign avs_readdata = s.readdata;
    assign frame_timer_expired = s.expire_pulse;
    assign timer_state = s.ft_state;
    assign irq = |(s.irq_status & s.irq_mask);

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_clk_one_route: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
        (s.src_sel[1:0] == 2'h3 |-> raw_sel[0] == front_digital_line[0]) and
        (s.src_sel[1] == 1'b0 |-> raw_sel[0] == int_conv_clock_one))
        else $error("clock one routed from wrong source");

    a_clk_two_route: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
        (s.src_sel[3:2] == 2'h2 |-> raw_sel[1] == rear_conv_clock_two_in) and
        (s.src_sel[3:2] == 2'h3 |-> raw_sel[1] == front_digital_line[2]))
        else $error("clock two routed from wrong source");

    a_trig_route: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
        (s.src_sel[5:4] == 2'h3 |-> raw_sel[2] == front_digital_line[4]) and
        (s.src_sel[5:4] == 2'h2 |-> raw_sel[2] == rear_frame_trigger_in))
        else $error("frame trigger routed from wrong source");

    a_reset_defaults: assert property (@(posedge ref_clk) // RULE_04
        $fell(rst) |-> s.src_sel == 6'h00 && !s.ft_enable && s.ft_reload == 28'hfffffff)
        else $error("reset values wrong");

    a_trig_restart: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
        clk_en && trig_rise && s.ft_enable |=> s.ft_count == 28'h0000000 && s.ft_state == FT_RUN)
        else $error("trigger did not restart the frame timer");

    a_count_step: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
        clk_en && s.ft_enable && s.ft_state == FT_RUN && !trig_rise && s.ft_count != s.ft_reload &&
        (s.ft_clk_sel ? sync_rise[1] : sync_rise[0])
        |=> s.ft_count == 28'($past(s.ft_count) + 28'h0000001))
        else $error("frame timer did not count selected clock");

    a_expire_time: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
        clk_en && s.ft_enable && s.ft_state == FT_RUN && !trig_rise && clk_rise && s.ft_count == s.ft_reload
        |=> s.ft_flag && frame_timer_expired && s.ft_state == FT_DONE)
        else $error("frame timer expiry missed");

    a_flag_cause: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
        $rose(s.ft_flag) |-> $past(s.ft_state) == FT_RUN && frame_timer_expired)
        else $error("expiry flag set without expiry");

    a_flag_clear: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
        clk_en && trig_rise |=> !s.ft_flag)
        else $error("trigger did not clear expiry flag");

    a_line_readback: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
        avs_read && s.ack && $past(clk_en) && $past(avs_read) && avs_address == `ADDR_LINE_INPUTS &&
        $past(avs_address) == `ADDR_LINE_INPUTS
        |-> avs_readdata == {12'h000, $past(front_digital_line)})
        else $error("line levels read back wrong");

    a_one_wait_state: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && req && !s.ack |=> !clk_en || !req || !avs_waitrequest)
        else $error("bus answer not after one wait state");

endmodule : conversion_signal_mux_frame_timer

`default_nettype wire

// *** dv/conv_source_model.sv ***
// model of the timing sources: internal generators, rear inputs, front lines
// assumes the bench calls its tasks; levels change right after ref_clk edges
`timescale 1ns/1ps
`default_nettype none

module conv_source_model (
    input wire logic ref_clk, // logic clock
    output logic [25:0] src // [2:0] internal, [5:3] rear, [25:6] front
);
    // ------------------------------------------------------------------------
    // level control
    // ------------------------------------------------------------------------
    initial src = 26'h0;

    // sets every source level at once
    task automatic drive(input logic [25:0] v);
        @(posedge ref_clk);
        src <= v;
    endtask : drive

    // slow pulses, four cycles high and four low, so no rise is lost
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            src[idx] <= 1'b1;
            repeat (4) @(posedge ref_clk);
            src[idx] <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask : pulse
endmodule : conv_source_model
`default_nettype wire

// *** dv/tb_conversion_signal_mux_frame_timer.sv ***
// self-checking bench for the source mux and frame timer
// assumes the source model and the register map header
`timescale 1ns/1ps
`default_nettype none
`include "conv_mux_map.svh"

module tb_conversion_signal_mux_frame_timer;
    import conv_mux_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] be = 4'hf;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [25:0] src;
    logic seq_one, seq_two, seq_trig, expired, irq;
    ft_state_t timer_state;
    logic [31:0] rdata;
    logic [25:0] m;
    int num_errors = 0;
    int n_compared = 0;
    int expiry_count = 0;

    // ------------------------------------------------------------------------
    // design and sources
    // ------------------------------------------------------------------------
    conversion_signal_mux_frame_timer conversion_signal_mux_frame_timer_inst (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .int_conv_clock_one(src[0]), .int_conv_clock_two(src[1]),
        .int_frame_trigger(src[2]), .rear_conv_clock_one_in(src[3]),
        .rear_conv_clock_two_in(src[4]), .rear_frame_trigger_in(src[5]),
        .front_digital_line(src[25:6]), .seq_conv_clock_one(seq_one),
        .seq_conv_clock_two(seq_two), .seq_frame_trigger(seq_trig),
        .frame_timer_expired(expired), .timer_state(timer_state), .irq(irq)
    );

    conv_source_model conv_source_model_inst (.ref_clk(ref_clk), .src(src));

    // 40 mhz clock
    always #12.5 ref_clk = ~ref_clk;

    // counts expiry pulses
    always @(posedge ref_clk)
        if (expired === 1'b1) expiry_count <= expiry_count + 1;

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon access, held until waitrequest is sampled low; the watchdog ends a hang
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do
        begin
            @(posedge ref_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask : rd

    // lets n edges pass, then samples mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    task automatic pulse(input int idx, input int n);
        conv_source_model_inst.pulse(idx, n);
    endtask : pulse

    // ------------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`ADDR_SOURCE_SELECT, 32'h0);
        rd(`ADDR_FRAME_TIMER, 32'h0fffffff);
        rd(`ADDR_IRQ_STATUS, 32'h0);
        rd(`ADDR_IRQ_MASK, 32'h0);
        wr(`ADDR_SOURCE_SELECT, 32'hffffffff);
        rd(`ADDR_SOURCE_SELECT, 32'h3f);
        wr(`ADDR_FRAME_TIMER, 32'h3fffffff);
        rd(`ADDR_FRAME_TIMER, 32'h0fffffff);
        wr(12'h400, 32'hffffffff);
        rd(12'h400, 32'h0);
        // line levels, also with a write attempt
        conv_source_model_inst.drive({20'ha5c3f, 6'h0});
        rd(`ADDR_LINE_INPUTS, 32'h000a5c3f);
        conv_source_model_inst.drive({20'h5a3c0, 6'h0});
        wr(`ADDR_LINE_INPUTS, 32'hffffffff);
        rd(`ADDR_LINE_INPUTS, 32'h0005a3c0);
        // every source code: selected source high, then all others high
        for (int s = 0; s < 4; s++)
        begin
            m = (s < 2) ? 26'h7 : (s == 2) ? 26'h38 : 26'h540;
            wr(`ADDR_SOURCE_SELECT, {26'h0, s[1:0], s[1:0], s[1:0]});
            conv_source_model_inst.drive(m);
            settle(4);
            check({29'h0, seq_trig, seq_two, seq_one}, 32'h7);
            conv_source_model_inst.drive(~m);
            settle(4);
            check({29'h0, seq_trig, seq_two, seq_one}, 32'h0);
        end
        conv_source_model_inst.drive(26'h0);
        wr(`ADDR_SOURCE_SELECT, 32'h0);
        wr(`ADDR_IRQ_STATUS, 32'h3);
        // timer on clock one, reload 2
        wr(`ADDR_FRAME_TIMER, 32'h80000002);
        pulse(2, 1);
        pulse(0, 2);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'h80000002);
        check({30'h0, timer_state}, {30'h0, FT_RUN});
        pulse(0, 1);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'ha0000002);
        check({30'h0, timer_state}, {30'h0, FT_DONE});
        check(32'(expiry_count), 32'h1);
        check({31'h0, irq}, 32'h0);
        rd(`ADDR_IRQ_STATUS, 32'h3);
        wr(`ADDR_IRQ_MASK, 32'h1);
        settle(1);
        check({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_STATUS, 32'h1);
        settle(1);
        check({31'h0, irq}, 32'h0);
        rd(`ADDR_IRQ_STATUS, 32'h2);
        // next trigger clears the flag; a retrigger restarts the count
        pulse(2, 1);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'h80000002);
        pulse(0, 2);
        pulse(2, 1);
        pulse(0, 2);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'h80000002);
        pulse(0, 1);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'ha0000002);
        // timer on clock two ignores clock one
        wr(`ADDR_FRAME_TIMER, 32'hc0000002);
        pulse(2, 1);
        pulse(0, 3);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'hc0000002);
        pulse(1, 3);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'he0000002);
        // disabled: trigger still clears, no expiry
        wr(`ADDR_FRAME_TIMER, 32'h00000002);
        pulse(2, 1);
        pulse(0, 3);
        settle(6);
        rd(`ADDR_FRAME_TIMER, 32'h00000002);
        check(32'(expiry_count), 32'h3);
        // single byte lane write keeps the other lanes
        be <= 4'h1;
        wr(`ADDR_FRAME_TIMER, 32'hffffff07);
        be <= 4'hf;
        rd(`ADDR_FRAME_TIMER, 32'h00000007);
        // clock enable low freezes the synchroniser
        clk_en <= 1'b0;
        conv_source_model_inst.drive(26'h7);
        settle(4);
        check({29'h0, seq_trig, seq_two, seq_one}, 32'h0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        settle(4);
        check({29'h0, seq_trig, seq_two, seq_one}, 32'h7);
        report_and_stop();
    end
endmodule : tb_conversion_signal_mux_frame_timer
`default_nettype wire
